// File: pkg/bca_pkg.sv
package bca_pkg;

    // ------------------------------------------------------------------
    // bus and clock
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 13;
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          BLOCK_TIME_NS = 50000;
    localparam int          BLOCK_CYCLES  = BLOCK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  AXI_OKAY      = 2'b00;
    localparam logic [1:0]  AXI_SLVERR    = 2'b10;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [10:0] IDX_CTRL      = 11'h540;
    localparam logic [10:0] IDX_DATA0     = 11'h548;
    localparam logic [10:0] IDX_DATA3     = 11'h54B;
    localparam logic [10:0] IDX_KEY0      = 11'h550;
    localparam logic [10:0] IDX_KEY15     = 11'h55F;
    localparam logic [10:0] IDX_IRQ_STAT  = 11'h560;
    localparam logic [10:0] IDX_IRQ_MASK  = 11'h561;
    localparam logic [10:0] IDX_DMA_CFG   = 11'h562;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int          CTRL_DIR_BIT  = 0;
    localparam int          CTRL_NEED_BIT = 1;
    localparam int          CTRL_RDY_BIT  = 2;
    localparam int          CTRL_CCM_BIT  = 7;
    localparam logic [7:0]  CTRL_RST      = 8'h02;
    localparam int          IRQ_DONE_BIT  = 0;
    localparam int          IRQ_NEED_BIT  = 1;
    localparam logic [1:0]  IRQ_RST       = 2'h0;

    // ------------------------------------------------------------------
    // cipher constants
    // ------------------------------------------------------------------
    localparam logic [3:0]  AES_ROUNDS    = 4'hA;
    localparam logic [7:0]  RCON_INIT     = 8'h01;
    localparam logic [7:0]  RCON_WRAP     = 8'h80;
    localparam logic [7:0]  GF_POLY       = 8'h1B;
    localparam logic [7:0]  SBOX_AFF      = 8'h63;
    localparam logic [7:0]  ISBOX_AFF     = 8'h05;
    localparam logic [31:0] MIX_FWD       = 32'h02030101;
    localparam logic [31:0] MIX_INV       = 32'h0E0B0D09;

    typedef enum logic [1:0] {CS_IDLE, CS_KEYFWD, CS_ROUND} bca_core_t;

endpackage

// File: rtl/bca_top.sv
// Function
// - the engine turns a 128-bit block into its cipher or plain form using the loaded key.
// - one block finishes well inside a thousand clock cycles after its input is complete.
// - the key lives in sixteen writable byte registers at consecutive addresses.
// - control bit 0 picks the direction, one for decrypt and zero for encrypt.
// - when encrypting, sixteen window byte writes bring in plaintext and sixteen byte reads return ciphertext.
// - when decrypting, sixteen window byte writes bring in ciphertext and sixteen byte reads return plaintext.
// - control bit 1 shows input is needed and drops after the fourth write to the last window byte.
// - control bit 2 rises when a block finishes and drops after the fourth read of the last window byte.
// - in stream mode only key and direction are set and block data moves over the stream.
// - with chaining off, the default, a result depends only on the current block and key.
// - with control bit 7 set, each result also folds in the previous ciphertext block.
// - after reset the control register reads input needed, no output, encrypt, no chaining.
`timescale 1ns/1ns
module bca_top
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [bca_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [bca_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    output logic                             irq,
    input  wire logic [31:0]                 dma_in_data,
    input  wire logic                        dma_in_valid,
    output logic                             dma_in_ready,
    output logic [31:0]                      dma_out_data,
    output logic                             dma_out_valid,
    input  wire logic                        dma_out_ready
);
    import bca_pkg::*;

    // ------------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] xtime(input logic [7:0] x);
        return {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i]) p ^= x;
            x = xtime(x);
        end
        return p;
    endfunction

    // inverse as a^254, zero maps to zero
    function automatic logic [7:0] gf_inv(input logic [7:0] a);
        logic [7:0] p;
        logic [7:0] r;
        p = a;
        r = 8'h01;
        for (int i = 1; i < 8; i++)
        begin
            p = gf_mul(p, p);
            r = gf_mul(r, p);
        end
        return r;
    endfunction

    function automatic logic [7:0] rl(input logic [7:0] x, input int n);
        return 8'((x << n) | (x >> (8 - n)));
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] b;
        b = gf_inv(x);
        return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ SBOX_AFF;
    endfunction

    function automatic logic [7:0] isbox(input logic [7:0] x);
        return gf_inv(rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ ISBOX_AFF);
    endfunction

    // one full round, byte i of the block at bits 127-8i
    function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] rk,
                                               input logic inv, input logic last);
        logic [127:0] t;
        logic [7:0]   a [4];
        logic [31:0]  m;
        logic [7:0]   o;
        t = '0;
        m = inv ? MIX_INV : MIX_FWD;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                t[127-8*(r+4*c) -: 8] = inv ? isbox(s[127-8*(r+4*((c+4-r)%4)) -: 8])
                                            : sbox(s[127-8*(r+4*((c+r)%4)) -: 8]);
        if (inv) t ^= rk;
        if (!last)
        begin
            for (int c = 0; c < 4; c++)
            begin
                for (int j = 0; j < 4; j++) a[j] = t[127-8*(j+4*c) -: 8];
                for (int r = 0; r < 4; r++)
                begin
                    o = 8'h00;
                    for (int j = 0; j < 4; j++) o ^= gf_mul(a[j], m[31-8*((j+4-r)%4) -: 8]);
                    t[127-8*(r+4*c) -: 8] = o;
                end
            end
        end
        if (!inv) t ^= rk;
        return t;
    endfunction

    function automatic logic [31:0] sub_rot(input logic [31:0] w, input logic [7:0] rc);
        return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
    endfunction

    function automatic logic [127:0] key_fwd(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] w0, w1, w2, w3;
        {w0, w1, w2, w3} = k;
        w0 ^= sub_rot(w3, rc);
        w1 ^= w0;
        w2 ^= w1;
        w3 ^= w2;
        return {w0, w1, w2, w3};
    endfunction

    function automatic logic [127:0] key_bwd(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] w0, w1, w2, w3;
        {w0, w1, w2, w3} = k;
        w3 ^= w2;
        w2 ^= w1;
        w1 ^= w0;
        w0 ^= sub_rot(w3, rc);
        return {w0, w1, w2, w3};
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic              awv_q, wv_q, bvalid_q, rvalid_q;
    logic [10:0]       widx_q;
    logic [7:0]        wd_q;
    logic              wlane_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [7:0]        rbyte_q;
    logic              dir_q, ccm_q, need_q, rdy_q, dma_en_q, start_q;
    logic [127:0]      key_q, in_q, out_q, chain_q, civ_q, st_q, rk_q;
    logic [23:0]       wbuf_q;
    logic [1:0]        in_cnt_q, out_cnt_q, irq_stat_q, irq_mask_q;
    logic [7:0]        rcon_q;
    logic [3:0]        rnd_q;
    logic              cdec_q, cccm_q;
    bca_core_t         cs_q;
    logic              wr_en, rd_en, w_ok, r_ok, push, pop, done;
    logic [10:0]       ridx;
    logic [7:0]        rd_b, rc_b;
    logic [31:0]       push_word;
    logic [127:0]      kf, kb, st_nx, result, cmask;

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    function automatic logic mapped(input logic [10:0] i);
        return i == IDX_CTRL || (i >= IDX_DATA0 && i <= IDX_DATA3) ||
               (i >= IDX_KEY0 && i <= IDX_KEY15) || (i >= IDX_IRQ_STAT && i <= IDX_DMA_CFG);
    endfunction

    assign awready = !awv_q;
    assign wready  = !wv_q;
    assign arready = !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = {24'h000000, rbyte_q};
    assign wr_en   = awv_q && wv_q && !bvalid_q;
    assign w_ok    = wr_en && wlane_q && mapped(widx_q);
    assign ridx    = araddr[12:2];
    assign rd_en   = arvalid && !rvalid_q;
    assign r_ok    = rd_en && mapped(ridx);

    // address and data held separately, either may come first
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awv_q    <= 1'b0;
            wv_q     <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= AXI_OKAY;
            widx_q   <= '0;
            wd_q     <= 8'h00;
            wlane_q  <= 1'b0;
        end
        else
        begin
            if (awvalid && !awv_q)
            begin
                awv_q  <= 1'b1;
                widx_q <= awaddr[12:2];
            end
            if (wvalid && !wv_q)
            begin
                wv_q    <= 1'b1;
                wd_q    <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            if (wr_en)
            begin
                awv_q    <= 1'b0;
                wv_q     <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(widx_q) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (bready) bvalid_q <= 1'b0;
        end
    end

    // read byte mux
    always_comb
    begin
        rd_b = 8'h00;
        if (ridx == IDX_CTRL)
            rd_b = {ccm_q, 4'h0, rdy_q, need_q, dir_q};
        else if (ridx >= IDX_DATA0 && ridx <= IDX_DATA3)
            rd_b = out_q[127-8*ridx[1:0] -: 8];
        else if (ridx >= IDX_KEY0 && ridx <= IDX_KEY15)
            rd_b = key_q[127-8*ridx[3:0] -: 8];
        else if (ridx == IDX_IRQ_STAT)
            rd_b = {6'h00, irq_stat_q};
        else if (ridx == IDX_IRQ_MASK)
            rd_b = {6'h00, irq_mask_q};
        else if (ridx == IDX_DMA_CFG)
            rd_b = {7'h00, dma_en_q};
    end

    // read answer one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= AXI_OKAY;
            rbyte_q  <= 8'h00;
        end
        else if (rd_en)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= r_ok ? AXI_OKAY : AXI_SLVERR;
            rbyte_q  <= rd_b;
        end
        else if (rready) rvalid_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir_q      <= CTRL_RST[CTRL_DIR_BIT];
            ccm_q      <= CTRL_RST[CTRL_CCM_BIT];
            key_q      <= '0;
            irq_mask_q <= IRQ_RST;
            dma_en_q   <= 1'b0;
            wbuf_q     <= '0;
        end
        else if (w_ok)
        begin
            if (widx_q == IDX_CTRL)
            begin
                dir_q <= wd_q[CTRL_DIR_BIT];
                ccm_q <= wd_q[CTRL_CCM_BIT];
            end
            if (widx_q >= IDX_KEY0 && widx_q <= IDX_KEY15)
                key_q[127-8*widx_q[3:0] -: 8] <= wd_q;
            if (widx_q >= IDX_DATA0 && widx_q < IDX_DATA3)
                wbuf_q[23-8*widx_q[1:0] -: 8] <= wd_q;
            if (widx_q == IDX_IRQ_MASK) irq_mask_q <= wd_q[1:0];
            if (widx_q == IDX_DMA_CFG) dma_en_q <= wd_q[0];
        end
    end

    // ------------------------------------------------------------------
    // data window and stream side
    // ------------------------------------------------------------------
    assign dma_in_ready  = dma_en_q && need_q;
    assign dma_out_valid = dma_en_q && rdy_q;
    assign dma_out_data  = out_q[127:96];
    assign push_word     = dma_en_q ? dma_in_data : {wbuf_q, wd_q};
    assign push = dma_en_q ? (dma_in_valid && need_q)
                           : (w_ok && widx_q == IDX_DATA3 && need_q);
    assign pop  = dma_en_q ? (dma_out_ready && rdy_q)
                           : (r_ok && ridx == IDX_DATA3 && rdy_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            need_q    <= CTRL_RST[CTRL_NEED_BIT];
            rdy_q     <= CTRL_RST[CTRL_RDY_BIT];
            in_q      <= '0;
            out_q     <= '0;
            in_cnt_q  <= 2'h0;
            out_cnt_q <= 2'h0;
            start_q   <= 1'b0;
        end
        else
        begin
            start_q <= push && in_cnt_q == 2'h3;
            if (push)
            begin
                in_q     <= {in_q[95:0], push_word};
                in_cnt_q <= in_cnt_q + 2'h1;
                if (in_cnt_q == 2'h3) need_q <= 1'b0;
            end
            if (done)
            begin
                out_q <= result;
                rdy_q <= 1'b1;
            end
            else if (pop)
            begin
                out_q     <= {out_q[95:0], 32'h00000000};
                out_cnt_q <= out_cnt_q + 2'h1;
                if (out_cnt_q == 2'h3)
                begin
                    rdy_q  <= 1'b0;
                    need_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // cipher core, one round per cycle
    // ------------------------------------------------------------------
    assign rc_b   = (rcon_q == GF_POLY) ? RCON_WRAP : (rcon_q >> 1);
    assign kf     = key_fwd(rk_q, rcon_q);
    assign kb     = key_bwd(rk_q, rc_b);
    assign st_nx  = aes_round(st_q, cdec_q ? kb : kf, cdec_q, rnd_q == AES_ROUNDS);
    assign done   = cs_q == CS_ROUND && rnd_q == AES_ROUNDS;
    assign cmask  = ccm_q ? chain_q : '0;
    assign result = cdec_q && cccm_q ? st_nx ^ chain_q : st_nx;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cs_q   <= CS_IDLE;
            st_q   <= '0;
            rk_q   <= '0;
            civ_q  <= '0;
            rcon_q <= RCON_INIT;
            rnd_q  <= 4'h0;
            cdec_q <= 1'b0;
            cccm_q <= 1'b0;
        end
        else
        begin
            unique case (cs_q)
                CS_IDLE:
                    if (start_q)
                    begin
                        cdec_q <= dir_q;
                        cccm_q <= ccm_q;
                        rk_q   <= key_q;
                        civ_q  <= in_q;
                        rcon_q <= RCON_INIT;
                        rnd_q  <= 4'h1;
                        st_q   <= dir_q ? in_q : in_q ^ cmask ^ key_q;
                        cs_q   <= dir_q ? CS_KEYFWD : CS_ROUND;
                    end
                CS_KEYFWD:
                begin
                    rk_q   <= kf;
                    rcon_q <= xtime(rcon_q);
                    rnd_q  <= rnd_q + 4'h1;
                    if (rnd_q == AES_ROUNDS)
                    begin
                        st_q  <= st_q ^ kf;
                        rnd_q <= 4'h1;
                        cs_q  <= CS_ROUND;
                    end
                end
                CS_ROUND:
                begin
                    st_q   <= st_nx;
                    rk_q   <= cdec_q ? kb : kf;
                    rcon_q <= cdec_q ? rc_b : xtime(rcon_q);
                    rnd_q  <= rnd_q + 4'h1;
                    if (done) cs_q <= CS_IDLE;
                end
            endcase
        end
    end

    // chain value, ciphertext of the previous block either way
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !ccm_q) chain_q <= '0;
        else if (done) chain_q <= cdec_q ? civ_q : st_nx;
    end

    // ------------------------------------------------------------------
    // interrupts, set wins over write-one-to-clear
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn) irq_stat_q <= IRQ_RST;
        else
        begin
            irq_stat_q <= (irq_stat_q & ~((w_ok && widx_q == IDX_IRQ_STAT) ? wd_q[1:0] : 2'h0))
                        | {pop && out_cnt_q == 2'h3 && !done, done};
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_need_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        push && in_cnt_q == 2'h3 |=> !need_q ##1 !need_q) else $error("need flag not cleared");
    a_rdy_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        done |=> rdy_q && !need_q) else $error("ready flag not set at finish");
    a_read_out: assert property (@(posedge aclk) disable iff (!aresetn)
        pop && out_cnt_q == 2'h3 && !done |=> !rdy_q && need_q) else $error("flags wrong after read");
    a_block_time: assert property (@(posedge aclk) disable iff (!aresetn)
        start_q |-> ##[1:1000] done) else $error("block took too long");
    a_dir_taken: assert property (@(posedge aclk) disable iff (!aresetn)
        start_q && cs_q == CS_IDLE |=> cdec_q == $past(dir_q)) else $error("direction not taken");
    a_reset_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> {ccm_q, 4'h0, rdy_q, need_q, dir_q} == CTRL_RST)
        else $error("control reset value wrong");
    a_key_store: assert property (@(posedge aclk) disable iff (!aresetn)
        w_ok && widx_q == IDX_KEY0 |=> key_q[127:120] == $past(wd_q)) else $error("key byte lost");
    a_plain_start: assert property (@(posedge aclk) disable iff (!aresetn)
        start_q && cs_q == CS_IDLE && !ccm_q && !dir_q |=> st_q == $past(in_q ^ key_q))
        else $error("chain leaked into plain mode");
    a_ccm_start: assert property (@(posedge aclk) disable iff (!aresetn)
        start_q && cs_q == CS_IDLE && ccm_q && !dir_q |=> st_q == $past(in_q ^ key_q ^ chain_q))
        else $error("chain not folded in");
    a_stream_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !dma_en_q |-> !dma_in_ready && !dma_out_valid) else $error("stream active in cpu mode");

endmodule

// File: tb/bca_dma_model.sv
`timescale 1ns/1ns
module bca_dma_model
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         go,
    input  wire logic [127:0] blk_in,
    output logic      [127:0] blk_out,
    output logic              done,
    output logic      [31:0]  dma_in_data,
    output logic              dma_in_valid,
    input  wire logic         dma_in_ready,
    input  wire logic [31:0]  dma_out_data,
    input  wire logic         dma_out_valid,
    output logic              dma_out_ready
);
    logic [1:0] i_q;
    logic [1:0] o_q;
    // four words in, first word is block bytes 0..3; pattern changes while idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {dma_in_valid, dma_in_data, i_q} <= '0;
        else if (go)
            {dma_in_valid, dma_in_data, i_q} <= {1'b1, blk_in[127:96], 2'h1};
        else if (dma_in_valid && dma_in_ready)
            {dma_in_valid, dma_in_data, i_q} <= {i_q != 2'h0,
                (i_q != 2'h0) ? blk_in[127 - 32 * i_q -: 32] : ~blk_in[127:96], i_q + 2'h1};
        else if (!dma_in_valid)
            dma_in_data <= ~dma_in_data;
    end
    // four words out, ready drops every other cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn || go)
            {dma_out_ready, o_q, done} <= '0;
        else
        begin
            dma_out_ready <= !dma_out_ready;
            if (dma_out_valid && dma_out_ready)
                blk_out[127 - 32 * o_q -: 32] <= dma_out_data;
            if (dma_out_valid && dma_out_ready)
                {o_q, done} <= {o_q + 2'h1, o_q == 2'h3};
        end
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    import bca_pkg::*;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
    logic rready = '0, go = '0, done, awready, wready, bvalid, arready, rvalid, irq;
    logic dma_in_valid, dma_in_ready, dma_out_valid, dma_out_ready;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata, dma_in_data, dma_out_data;
    logic [3:0]        wstrb = 4'hF;
    logic [1:0]        bresp, rresp, r;
    logic [7:0]        b;
    logic [127:0]      pt, c1, c2, c3, so;
    int                mismatches = 0, n_checks = 0;
    localparam logic [127:0] K0 = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] C0 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    bca_top u_bca_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq, .dma_in_data, .dma_in_valid, .dma_in_ready, .dma_out_data,
        .dma_out_valid, .dma_out_ready);
    bca_dma_model u_bca_dma_model (.aclk, .aresetn, .go, .blk_in(pt), .blk_out(so), .done,
        .dma_in_data, .dma_in_valid, .dma_in_ready, .dma_out_data, .dma_out_valid, .dma_out_ready);
    initial forever #25 aclk = ~aclk;
    // hang guard
    initial
    begin
        repeat (12000) @(posedge aclk);
        mismatches++;
        tally_and_finish();
    end
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic pa, pw;
        {pa, pw} = 2'b11;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
        while (pa || pw)
        begin
            @(posedge aclk);
            {pa, pw} = {pa & !awready, pw & !wready};
            {awvalid, wvalid} <= {pa, pw};
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [12:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        {b, r} = {rdata[7:0], rresp};
        rready <= 1'b0;
    endtask
    task automatic ldkey(input logic [127:0] k);
        for (int i = 0; i < 16; i++)
        begin
            wr(13'h1540 + 13'(4 * i), k[127 - 8 * i -: 8]);
            rd(13'h1540 + 13'(4 * i));
            chk("key", k[127 - 8 * i -: 8], b);
        end
    endtask
    task automatic blk(input logic [127:0] din, output logic [127:0] dout);
        int n;
        for (int i = 0; i < 16; i++) wr(13'h1520 + 13'(4 * (i % 4)), din[127 - 8 * i -: 8]);
        rd(13'h1500);
        chk("need", 0, b[2:1]);
        n = 0;
        while (b[2] !== 1'b1 && n++ < 250) rd(13'h1500);
        chk("ready", 1, b[2]);
        for (int i = 0; i < 16; i++)
        begin
            rd(13'h1520 + 13'(4 * (i % 4)));
            dout[127 - 8 * i -: 8] = b;
        end
        rd(13'h1500);
        chk("need back", 1, b[2:1]);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        void'($urandom(45441));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(13'h1500);
        chk("ctrl", CTRL_RST, b);
        rd(13'h1FFC);
        chk("unmapped", AXI_SLVERR, r);
        wr(13'h1FFC, 8'h00);
        chk("unmapped wr", AXI_SLVERR, r);
        pt = 128'h00112233445566778899AABBCCDDEEFF;
        ldkey(K0);
        blk(pt, c1);
        chk("encrypt", C0, c1);
        chk("irq masked", 0, irq);
        wr(13'h1584, 8'h01);
        chk("wr resp", AXI_OKAY, r);
        rd(13'h1580);
        chk("irq set", 9'h007, {b, irq});
        wr(13'h1580, 8'h03);
        rd(13'h1580);
        chk("irq clear", 0, {b, irq});
        wr(13'h1500, 8'h01);
        blk(C0, c2);
        chk("decrypt", pt, c2);
        $display("test vector done");
        repeat (2)
        begin
            ldkey({$urandom, $urandom, $urandom, $urandom});
            pt = {$urandom, $urandom, $urandom, $urandom};
            wr(13'h1500, 8'h80);
            blk(pt, c1);
            blk(pt, c2);
            wr(13'h1500, 8'h00);
            blk(pt ^ c1, c3);
            chk("chain", c3, c2);
            wr(13'h1500, 8'h01);
            blk(c1, c3);
            chk("round trip", pt, c3);
            wr(13'h1500, 8'h81);
            blk(c1, c3);
            chk("chain dec first", pt, c3);
            blk(c2, c3);
            chk("chain dec", pt, c3);
            wr(13'h1500, 8'h00);
        end
        $display("test random done");
        ldkey(K0);
        pt = 128'h00112233445566778899AABBCCDDEEFF;
        wr(13'h1500, 8'h00);
        wr(13'h1588, 8'h01);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        for (int n = 0; n < 200 && done !== 1'b1; n++) @(posedge aclk);
        chk("stream", C0, so);
        $display("test stream done");
        tally_and_finish();
    end
endmodule
